/* rtl/gpfm_pin_cell.sv */
// One pin cell: output mux, open-drain handling, stop gating and input gating.
// Assumes the pad resolves the wire level from padOut and padOe.
`timescale 1ns/10ps
`default_nettype none
module gpfm_pin_cell (
  input wire logic portData,
  input wire logic portOutEn,
  input wire logic altSel,
  input wire logic altOut,
  input wire logic altOutEn,
  input wire logic openDrain,
  input wire logic pullEn,
  input wire logic inEnable,
  input wire logic intPath,
  input wire logic stopDrive,
  input wire logic padIn,
  output logic padOut,
  output logic padOe,
  output logic padPullup,
  output logic pinLevel,
  output logic intLevel
);
  logic drvVal;
  logic drvEn;

  // Port data or alternate output selects the driven value
  assign drvVal = altSel ? altOut : portData;
  assign drvEn = altSel ? altOutEn : portOutEn;

  // Open drain only ever pulls low; stop mode removes every drive
  assign padOut = openDrain ? 1'b0 : drvVal;
  assign padOe = drvEn & ~stopDrive & (openDrain ? ~drvVal : 1'b1);
  assign padPullup = pullEn & ~stopDrive;

  // Input buffer is closed unless enabled, and closed in stop mode
  assign pinLevel = padIn & inEnable & ~stopDrive;

  // Interrupt path stays open in stop mode for the selected pin
  assign intLevel = padIn & inEnable & (~stopDrive | intPath);
endmodule : gpfm_pin_cell
`default_nettype wire

/* rtl/gpfm_pkg.sv */
// Package for the eight-bit multiplexed port: register map, widths, reset values.
// Assumes a plain address/strobe register port with byte addresses.
package gpfm_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned GPFM_PINS = 8;
  localparam int unsigned GPFM_AW = 8;
  localparam int unsigned GPFM_DW = 32;
  localparam logic [31:0] GPFM_BASE_ADDR = 32'h4000_0140;

  // ----------------------------------------------------------------
  // Register offsets from the port base
  // ----------------------------------------------------------------
  localparam logic [7:0] GPFM_OFS_DATA = 8'h00;
  localparam logic [7:0] GPFM_OFS_OUTEN = 8'h04;
  localparam logic [7:0] GPFM_OFS_ALT1 = 8'h08;
  localparam logic [7:0] GPFM_OFS_ALT2 = 8'h0C;
  localparam logic [7:0] GPFM_OFS_ODRAIN = 8'h28;
  localparam logic [7:0] GPFM_OFS_PULLUP = 8'h2C;
  localparam logic [7:0] GPFM_OFS_INEN = 8'h38;

  // ----------------------------------------------------------------
  // Reset values and implemented bits
  // ----------------------------------------------------------------
  localparam logic [7:0] GPFM_RST_BYTE = 8'h00;
  localparam logic [7:0] GPFM_ALT2_MASK = 8'h04;

  // ----------------------------------------------------------------
  // Alternate function bit positions in the first select register; CTS is in the second
  // ----------------------------------------------------------------
  localparam int unsigned GPFM_BIT_UART_TX = 0;
  localparam int unsigned GPFM_BIT_UART_RX = 1;
  localparam int unsigned GPFM_BIT_UART_CLK = 2;
  localparam int unsigned GPFM_BIT_REMOTE = 3;
  localparam int unsigned GPFM_BIT_SER_OUT = 4;
  localparam int unsigned GPFM_BIT_SER_IN = 5;
  localparam int unsigned GPFM_BIT_SER_CLK = 6;
  localparam int unsigned GPFM_BIT_EXT_INT = 7;
  localparam int unsigned GPFM_BIT_CTS = 2;

endpackage : gpfm_pkg

/* rtl/gpfm_port.sv */
// Eight-bit general-purpose port with alternate function routing.
// Assumes a register port in the clk domain and pad inputs synchronous to clk.
//
// Summary of operation
// R1: Eight pins, each input or output.
// R2: Reset leaves pins plain, everything disabled.
// R3: Both select bits zero means plain pin.
// R4: Software never sets both select bits.
// R5: Route UART, remote input, serial bus, interrupt.
// R6: Software selects interrupt and enables input.
// R7: Interrupt input survives pin-drive stop.
// R8: Outside stop, enabled input reaches interrupt.
// R9: Software disables unused interrupt sources.
// R10: Data, output, select registers at offsets.
// R11: Open-drain, pull-up, input registers at offsets.
// R12: Data bits 7-0, upper bits zero.
// R13: Output enable bit per pin.
// R14: Select bits map to functions listed.
// R15: Open-drain bit picks push-pull or drain.
// R16: Pull-up and input bits enable buffers.
// R17: Output drives data; read returns input.
`timescale 1ns/10ps
`default_nettype none
module gpfm_port
#(
  parameter int unsigned PINS = gpfm_pkg::GPFM_PINS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [gpfm_pkg::GPFM_AW-1:0] regAddr,
  input wire logic [gpfm_pkg::GPFM_DW-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [gpfm_pkg::GPFM_DW-1:0] regRdata,
  input wire logic stopDrive,
  input wire logic [PINS-1:0] padIn,
  output logic [PINS-1:0] padOut,
  output logic [PINS-1:0] padOe,
  output logic [PINS-1:0] padPullup,
  input wire logic uartTxData,
  input wire logic uartTxOe,
  output logic uartRxData,
  input wire logic uartClkOut,
  input wire logic uartClkOe,
  output logic uartClkIn,
  output logic uartCtsIn,
  output logic remoteIn,
  input wire logic serOutData,
  input wire logic serOutOe,
  output logic serOutIn,
  input wire logic serInOut,
  input wire logic serInOe,
  output logic serInIn,
  input wire logic serClkOut,
  input wire logic serClkOe,
  output logic serClkIn,
  output logic extIntIn
);
  import gpfm_pkg::*;

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  // Function routing is wired to fixed pin numbers, so only eight pins work
  if (PINS != GPFM_PINS) begin : g_bad_pins
    $error("gpfm_port supports exactly eight pins");
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [PINS-1:0] pinData_q;
  logic [PINS-1:0] outEn_q;
  logic [PINS-1:0] alt1_q;
  logic [PINS-1:0] alt2_q;
  logic [PINS-1:0] openDrain_q;
  logic [PINS-1:0] pullup_q;
  logic [PINS-1:0] inEn_q;
  logic [GPFM_DW-1:0] rdata_q;
  logic [GPFM_DW-1:0] rdata_d;
  logic [PINS-1:0] pinLevel;
  logic [PINS-1:0] intLevel;
  logic [PINS-1:0] altSel;
  logic [PINS-1:0] altOut;
  logic [PINS-1:0] altOutEn;
  logic [PINS-1:0] wByte;

  assign wByte = regWdata[PINS-1:0];

  // Data register write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinData_q <= GPFM_RST_BYTE; // R2
    end else if (regWrite && regAddr == GPFM_OFS_DATA) begin // R10
      pinData_q <= wByte; // R12
    end
  end

  // Output enable register write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      outEn_q <= GPFM_RST_BYTE; // R2
    end else if (regWrite && regAddr == GPFM_OFS_OUTEN) begin // R10
      outEn_q <= wByte; // R13
    end
  end

  // Function select registers; only the clear-to-send bit exists in the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      alt1_q <= GPFM_RST_BYTE; // R2
      alt2_q <= GPFM_RST_BYTE;
    end else begin
      if (regWrite && regAddr == GPFM_OFS_ALT1) begin // R10
        alt1_q <= wByte; // R3
      end
      if (regWrite && regAddr == GPFM_OFS_ALT2) begin // R10
        alt2_q <= wByte & GPFM_ALT2_MASK; // R14
      end
    end
  end

  // Pad control registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      openDrain_q <= GPFM_RST_BYTE; // R15
      pullup_q <= GPFM_RST_BYTE; // R16
      inEn_q <= GPFM_RST_BYTE; // R2
    end else begin
      if (regWrite && regAddr == GPFM_OFS_ODRAIN) begin // R11
        openDrain_q <= wByte; // R15
      end
      if (regWrite && regAddr == GPFM_OFS_PULLUP) begin // R11
        pullup_q <= wByte; // R16
      end
      if (regWrite && regAddr == GPFM_OFS_INEN) begin // R11
        inEn_q <= wByte; // R16
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Unmapped offsets read zero; upper bits are always zero
  always_comb begin
    rdata_d = '0;
    if (regRead) begin
      unique case (regAddr)
        GPFM_OFS_DATA: rdata_d[PINS-1:0] = pinLevel; // R17
        GPFM_OFS_OUTEN: rdata_d[PINS-1:0] = outEn_q;
        GPFM_OFS_ALT1: rdata_d[PINS-1:0] = alt1_q;
        GPFM_OFS_ALT2: rdata_d[PINS-1:0] = alt2_q;
        GPFM_OFS_ODRAIN: rdata_d[PINS-1:0] = openDrain_q;
        GPFM_OFS_PULLUP: rdata_d[PINS-1:0] = pullup_q;
        GPFM_OFS_INEN: rdata_d[PINS-1:0] = inEn_q;
        default: rdata_d = '0;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d; // R12
    end
  end
  assign regRdata = rdata_q;

  // ----------------------------------------------------------------
  // Alternate function routing
  // ----------------------------------------------------------------
  // A pin is handed over when either select bit is set; both set is illegal
  assign altSel = alt1_q | alt2_q; // R3

  // Output side of each function; input-only functions never drive
  always_comb begin
    altOut = '0;
    altOutEn = '0;
    altOut[GPFM_BIT_UART_TX] = uartTxData; // R5
    altOutEn[GPFM_BIT_UART_TX] = uartTxOe;
    altOut[GPFM_BIT_UART_CLK] = uartClkOut;
    altOutEn[GPFM_BIT_UART_CLK] = uartClkOe & alt1_q[GPFM_BIT_UART_CLK]; // R14
    altOut[GPFM_BIT_SER_OUT] = serOutData;
    altOutEn[GPFM_BIT_SER_OUT] = serOutOe;
    altOut[GPFM_BIT_SER_IN] = serInOut;
    altOutEn[GPFM_BIT_SER_IN] = serInOe;
    altOut[GPFM_BIT_SER_CLK] = serClkOut;
    altOutEn[GPFM_BIT_SER_CLK] = serClkOe;
  end

  // Inputs reach a function only while its select bit is set
  assign uartRxData = pinLevel[GPFM_BIT_UART_RX] & alt1_q[GPFM_BIT_UART_RX]; // R14
  assign uartClkIn = pinLevel[GPFM_BIT_UART_CLK] & alt1_q[GPFM_BIT_UART_CLK];
  assign uartCtsIn = pinLevel[GPFM_BIT_CTS] & alt2_q[GPFM_BIT_CTS]; // R14
  assign remoteIn = pinLevel[GPFM_BIT_REMOTE] & alt1_q[GPFM_BIT_REMOTE]; // R5
  assign serOutIn = pinLevel[GPFM_BIT_SER_OUT] & alt1_q[GPFM_BIT_SER_OUT];
  assign serInIn = pinLevel[GPFM_BIT_SER_IN] & alt1_q[GPFM_BIT_SER_IN];
  assign serClkIn = pinLevel[GPFM_BIT_SER_CLK] & alt1_q[GPFM_BIT_SER_CLK];

  // Outside stop the interrupt ignores the select bit; software must disable unused inputs
  assign extIntIn = intLevel[GPFM_BIT_EXT_INT]; // R8

  // ----------------------------------------------------------------
  // Pin cells
  // ----------------------------------------------------------------
  // One cell per pin; only the interrupt pin keeps its input in stop mode
  for (genvar i = 0; i < PINS; i++) begin : g_pin // R1
    gpfm_pin_cell u_cell (
      .portData(pinData_q[i]), // R17
      .portOutEn(outEn_q[i]), // R13
      .altSel(altSel[i]),
      .altOut(altOut[i]),
      .altOutEn(altOutEn[i]),
      .openDrain(openDrain_q[i]),
      .pullEn(pullup_q[i]),
      .inEnable(inEn_q[i]),
      .intPath((i == GPFM_BIT_EXT_INT) ? alt1_q[i] : 1'b0), // R7
      .stopDrive(stopDrive),
      .padIn(padIn[i]),
      .padOut(padOut[i]),
      .padOe(padOe[i]),
      .padPullup(padPullup[i]),
      .pinLevel(pinLevel[i]),
      .intLevel(intLevel[i])
    );
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_reset_quiet;
    @(posedge clk) $past(!rst_n) |-> (padOe == '0 && padPullup == '0 && extIntIn == 1'b0);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("pins active after reset"); // R2

  property p_data_drive;
    @(posedge clk) disable iff (!rst_n)
      (outEn_q[0] && !altSel[0] && !openDrain_q[0] && !stopDrive) |-> (padOe[0] && padOut[0] == pinData_q[0]);
  endproperty
  a_data_drive: assert property (p_data_drive) else $error("enabled pin not driving data"); // R13

  property p_data_write;
    @(posedge clk) disable iff (!rst_n)
      (regWrite && regAddr == GPFM_OFS_DATA) |=> (pinData_q == $past(regWdata[PINS-1:0]));
  endproperty
  a_data_write: assert property (p_data_write) else $error("data register missed write"); // R10

  property p_read_back;
    @(posedge clk) disable iff (!rst_n)
      (regRead && regAddr == GPFM_OFS_INEN) |=> (regRdata == {24'h0000_00, $past(inEn_q)});
  endproperty
  a_read_back: assert property (p_read_back) else $error("input enable readback wrong"); // R11

  property p_upper_zero;
    @(posedge clk) disable iff (!rst_n) regRdata[GPFM_DW-1:PINS] == '0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero"); // R12

  property p_read_input;
    @(posedge clk) disable iff (!rst_n)
      (regRead && regAddr == GPFM_OFS_DATA && !stopDrive) |=> (regRdata[PINS-1:0] == $past(padIn & inEn_q));
  endproperty
  a_read_input: assert property (p_read_input) else $error("data read not pin level"); // R17

  property p_stop_int;
    @(posedge clk) disable iff (!rst_n)
      (stopDrive && alt1_q[GPFM_BIT_EXT_INT] && inEn_q[GPFM_BIT_EXT_INT]) |->
        (extIntIn == padIn[GPFM_BIT_EXT_INT]);
  endproperty
  a_stop_int: assert property (p_stop_int) else $error("interrupt lost in stop"); // R7

  property p_run_int;
    @(posedge clk) disable iff (!rst_n)
      (!stopDrive && inEn_q[GPFM_BIT_EXT_INT]) |-> (extIntIn == padIn[GPFM_BIT_EXT_INT]);
  endproperty
  a_run_int: assert property (p_run_int) else $error("interrupt blocked outside stop"); // R8

  property p_open_drain;
    @(posedge clk) disable iff (!rst_n)
      !stopDrive |-> ((((padOe ^ (outEn_q & ~pinData_q)) | padOut) & openDrain_q & ~altSel) == '0);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain drove high"); // R15

  property p_alt2_mask;
    @(posedge clk) disable iff (!rst_n) (alt2_q & ~GPFM_ALT2_MASK) == '0;
  endproperty
  a_alt2_mask: assert property (p_alt2_mask) else $error("unimplemented select bit set"); // R14

  // Every control register is clear straight after reset
  property p_reset_regs;
    @(posedge clk) $past(!rst_n) |->
      ((pinData_q | outEn_q | alt1_q | alt2_q | openDrain_q | pullup_q | inEn_q) == '0);
  endproperty
  a_reset_regs: assert property (p_reset_regs) else $error("register not cleared by reset"); // R2

  property p_outen_write;
    @(posedge clk) disable iff (!rst_n)
      (regWrite && regAddr == GPFM_OFS_OUTEN) |=> (outEn_q == $past(regWdata[PINS-1:0]));
  endproperty
  a_outen_write: assert property (p_outen_write) else $error("output enable missed write"); // R13

  property p_alt1_write;
    @(posedge clk) disable iff (!rst_n)
      (regWrite && regAddr == GPFM_OFS_ALT1) |=> (alt1_q == $past(regWdata[PINS-1:0]));
  endproperty
  a_alt1_write: assert property (p_alt1_write) else $error("first select missed write"); // R3

  property p_inen_write;
    @(posedge clk) disable iff (!rst_n)
      (regWrite && regAddr == GPFM_OFS_INEN) |=> (inEn_q == $past(regWdata[PINS-1:0]));
  endproperty
  a_inen_write: assert property (p_inen_write) else $error("input enable missed write"); // R16

  // Read data is a one-cycle pulse, so software never sees stale words
  property p_read_pulse;
    @(posedge clk) disable iff (!rst_n) !$past(regRead) |-> (regRdata == '0);
  endproperty
  a_read_pulse: assert property (p_read_pulse) else $error("read data outside its cycle"); // R12

  // Plain pins drive only from the port registers
  property p_plain_pin;
    @(posedge clk) disable iff (!rst_n)
      ((alt1_q | alt2_q) == '0 && !stopDrive) |-> (padOe == (outEn_q & ~(openDrain_q & pinData_q)));
  endproperty
  a_plain_pin: assert property (p_plain_pin) else $error("plain pin drive wrong"); // R3

  property p_tx_route;
    @(posedge clk) disable iff (!rst_n)
      (alt1_q[GPFM_BIT_UART_TX] && !openDrain_q[GPFM_BIT_UART_TX] && !stopDrive) |->
        (padOe[GPFM_BIT_UART_TX] == uartTxOe && padOut[GPFM_BIT_UART_TX] == uartTxData);
  endproperty
  a_tx_route: assert property (p_tx_route) else $error("transmit not routed to pin"); // R5

  property p_cts_route;
    @(posedge clk) disable iff (!rst_n)
      (alt2_q[GPFM_BIT_CTS] && inEn_q[GPFM_BIT_CTS] && !stopDrive) |-> (uartCtsIn == padIn[GPFM_BIT_CTS]);
  endproperty
  a_cts_route: assert property (p_cts_route) else $error("clear to send not routed"); // R14

  property p_stop_quiet;
    @(posedge clk) disable iff (!rst_n) stopDrive |-> ((padOe | padPullup) == '0);
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("pin driven in stop"); // R7

  property p_pullup_follow;
    @(posedge clk) disable iff (!rst_n) !stopDrive |-> (padPullup == pullup_q);
  endproperty
  a_pullup_follow: assert property (p_pullup_follow) else $error("pull-up not following register"); // R16

endmodule : gpfm_port
`default_nettype wire

/* verification/gpfm_board_model.sv */
// Board side of the multiplexed port: resolves each pad level for the port.
// Assumes the bench sets extDrv/extVal; a floating pin toggles so no stale level survives.
`timescale 1ns/10ps
`default_nettype none
module gpfm_board_model (
  input wire logic clk,
  input wire logic [7:0] padOut,
  input wire logic [7:0] padOe,
  input wire logic [7:0] padPullup,
  input wire logic [7:0] extDrv,
  input wire logic [7:0] extVal,
  output logic [7:0] padIn
);
  logic [7:0] floatPat_q = 8'hA5;
  // Undriven pin without pull-up changes every cycle, so a missed drive is seen
  always @(posedge clk) begin
    floatPat_q <= ~floatPat_q;
  end
  // Device drive wins, then the board, then the pull-up
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      padIn[k] = padOe[k] ? padOut[k] : extDrv[k] ? extVal[k] : padPullup[k] ? 1'b1 : floatPat_q[k];
    end
  end
endmodule : gpfm_board_model
`default_nettype wire

/* verification/tb.sv */
// Testbench for the eight-bit multiplexed port: registers, pin drive, routing, stop mode.
// Assumes the board model resolves pads; every design input is driven here.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import gpfm_pkg::*;
  logic clk, rst_n, regWrite, regRead, stopDrive, ctsIn;
  logic [7:0] regAddr, padIn, padOut, padOe, padPullup, extDrv, extVal, v, d, o;
  logic [7:1] fnIn;
  logic [4:0] fnOut, fnOe;
  logic [31:0] regWdata, regRdata, got;
  logic [7:0] offs [8];
  int mdl [int];
  int bad_count, checks, i;

  gpfm_port gpfm_port_inst (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .stopDrive(stopDrive), .padIn(padIn),
    .padOut(padOut), .padOe(padOe), .padPullup(padPullup), .uartTxData(fnOut[0]), .uartTxOe(fnOe[0]),
    .uartRxData(fnIn[1]), .uartClkOut(fnOut[1]), .uartClkOe(fnOe[1]), .uartClkIn(fnIn[2]), .uartCtsIn(ctsIn),
    .remoteIn(fnIn[3]), .serOutData(fnOut[2]), .serOutOe(fnOe[2]), .serOutIn(fnIn[4]), .serInOut(fnOut[3]),
    .serInOe(fnOe[3]), .serInIn(fnIn[5]), .serClkOut(fnOut[4]), .serClkOe(fnOe[4]), .serClkIn(fnIn[6]),
    .extIntIn(fnIn[7]));
  gpfm_board_model gpfm_board_model_inst (.clk(clk), .padOut(padOut), .padOe(padOe), .padPullup(padPullup),
    .extDrv(extDrv), .extVal(extVal), .padIn(padIn));

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  // Write updates the model too; the second select register keeps only its one bit
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    @(posedge clk);
    regAddr <= a;
    regWdata <= dat;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    if (mdl.exists(int'(a))) mdl[int'(a)] = int'(dat[7:0] & (a == GPFM_OFS_ALT2 ? GPFM_ALT2_MASK : 8'hFF));
  endtask : wr
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    got = regRdata;
  endtask : rd
  task automatic drive(input logic [7:0] en, input logic [7:0] val);
    @(posedge clk);
    extDrv <= en;
    extVal <= val;
    @(negedge clk);
  endtask : drive
  task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp32
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    cmp32({24'h00_0000, g}, {24'h00_0000, e});
  endtask : cmp8
  task automatic complete_run();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------
  // Clock, watchdog and scenarios
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // A hang is cut short and counted
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    complete_run();
  end
  initial begin
    {rst_n, regWrite, regRead, stopDrive, regAddr, regWdata, extDrv, extVal, fnOut, fnOe} = '0;
    offs = '{GPFM_OFS_DATA, GPFM_OFS_OUTEN, GPFM_OFS_ALT1, GPFM_OFS_ALT2, GPFM_OFS_ODRAIN, GPFM_OFS_PULLUP,
      GPFM_OFS_INEN, 8'h10};
    for (i = 0; i < 7; i++) mdl[int'(offs[i])] = 0;
    void'($urandom(12));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 8; i++) begin
      rd(offs[i]);
      cmp32(got, 32'h0000_0000);
    end
    cmp8(padOe | padPullup, 8'h00);
    $display("test reset_values done");
    // Random 32-bit words, upper bits included; the unmapped offset must not alias
    for (i = 1; i < 8; i++) wr(offs[i], $urandom & ~(i == 3 ? 32'(mdl[8]) : 32'h0000_0000));
    for (i = 1; i < 8; i++) begin
      rd(offs[i]);
      cmp32(got, mdl.exists(int'(offs[i])) ? 32'(mdl[int'(offs[i])]) : 32'h0000_0000);
    end
    for (i = 1; i < 7; i++) wr(offs[i], 32'h0000_0000);
    $display("test register_map done");
    wr(GPFM_OFS_INEN, 32'h0000_00FF);
    v = 8'($urandom);
    drive(8'hFF, v);
    rd(GPFM_OFS_DATA);
    cmp32(got, {24'h00_0000, v});
    d = 8'($urandom);
    o = 8'($urandom);
    wr(GPFM_OFS_DATA, {24'hFF_FFFF, d});
    wr(GPFM_OFS_ODRAIN, {24'h00_0000, o});
    wr(GPFM_OFS_PULLUP, 32'h0000_00FF);
    wr(GPFM_OFS_OUTEN, 32'h0000_00FF);
    drive(8'h00, v);
    cmp8(padOe, ~o | ~d);
    cmp8(padOut & ~o, d & ~o);
    cmp8(padOut & o, 8'h00);
    cmp8(padPullup, 8'hFF);
    rd(GPFM_OFS_DATA);
    cmp32(got, {24'h00_0000, d});
    v = 8'($urandom);
    wr(GPFM_OFS_INEN, {24'h00_0000, v});
    rd(GPFM_OFS_DATA);
    cmp32(got, {24'h00_0000, d & v});
    $display("test pin_drive done");
    wr(GPFM_OFS_OUTEN, 32'h0000_0000);
    wr(GPFM_OFS_ODRAIN, 32'h0000_0000);
    wr(GPFM_OFS_PULLUP, 32'h0000_0000);
    wr(GPFM_OFS_INEN, 32'h0000_00FF);
    wr(GPFM_OFS_ALT1, 32'h0000_00FF);
    v = 8'($urandom);
    drive(8'hFF, v);
    cmp8({fnIn, 1'b0}, {v[7:1], 1'b0});
    @(posedge clk);
    fnOut <= 5'($urandom);
    fnOe <= 5'h1F;
    extDrv <= 8'h8A;
    @(negedge clk);
    cmp8(padOe & 8'h75, 8'h75);
    cmp8(padOut & 8'h75, {1'b0, fnOut[4:2], 1'b0, fnOut[1], 1'b0, fnOut[0]});
    wr(GPFM_OFS_ALT1, 32'h0000_0000);
    wr(GPFM_OFS_ALT2, 32'hFFFF_FFFF);
    fnOe <= 5'h00;
    drive(8'hFF, v);
    cmp8({7'h00, ctsIn}, {7'h00, v[2]});
    cmp8({7'h00, fnIn[7]}, {7'h00, v[7]});
    $display("test alternate_routing done");
    wr(GPFM_OFS_ALT2, 32'h0000_0000);
    wr(GPFM_OFS_ALT1, 32'h0000_0080);
    wr(GPFM_OFS_OUTEN, 32'h0000_00FF);
    wr(GPFM_OFS_PULLUP, 32'h0000_00FF);
    stopDrive <= 1'b1;
    for (i = 0; i < 2; i++) begin
      drive(8'hFF, {i[0], 7'h55});
      cmp8(padOe | padPullup, 8'h00);
      cmp8({7'h00, fnIn[7]}, {7'h00, i[0]});
    end
    rd(GPFM_OFS_DATA);
    cmp32(got, 32'h0000_0000);
    wr(GPFM_OFS_ALT1, 32'h0000_0000);
    @(negedge clk);
    cmp8({7'h00, fnIn[7]}, 8'h00);
    @(posedge clk);
    stopDrive <= 1'b0;
    @(negedge clk);
    cmp8({7'h00, fnIn[7]}, 8'h01);
    wr(GPFM_OFS_INEN, 32'h0000_0000);
    @(negedge clk);
    cmp8({7'h00, fnIn[7]}, 8'h00);
    $display("test stop_mode done");
    complete_run();
  end
endmodule : tb
`default_nettype wire
